//--- inc/mct_regs.svh
/*
  Timing counts, widths and reset values for the match/capture timer.
  Assumes inclusion by bare name from design files.
*/
`ifndef MCT_REGS_SVH
`define MCT_REGS_SVH
`define MCT_CNT_W      32
`define MCT_NUM_MATCH  4
`define MCT_NUM_CAP    3
`define MCT_NUM_DMA    2
`define MCT_CNT_RST    32'h0000_0000
`define MCT_OUT_RST    4'h0
`define MCT_CLK_HZ     40000000
`endif

//--- inc/mct_pkg.sv
/*
  Types for the match/capture timer.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package mct_pkg;
  typedef enum logic [1:0] {
    MCT_EM_NONE   = 2'b00,
    MCT_EM_LOW    = 2'b01,
    MCT_EM_HIGH   = 2'b10,
    MCT_EM_TOGGLE = 2'b11
  } mct_emact_t;
  typedef enum logic [1:0] {
    MCT_RUN_IDLE = 2'b00,
    MCT_RUN_CNT  = 2'b01,
    MCT_RUN_HALT = 2'b10
  } mct_run_t;
endpackage : mct_pkg

//--- inc/mct_sync_if.sv
/*
  Carrier of the edge pulses of the synchronised external pins.
  Assumes one clock shared by both ends.
*/
`timescale 1ns/1ps
`default_nettype none
interface mct_sync_if;
  logic       cnt_rise;
  logic       cnt_fall;
  logic [2:0] cap_rise;
  logic [2:0] cap_fall;
  modport src (output cnt_rise, output cnt_fall, output cap_rise, output cap_fall);
  modport dst (input cnt_rise, input cnt_fall, input cap_rise, input cap_fall);
endinterface : mct_sync_if
`default_nettype wire

//--- verilog/mct_edge_sync.sv
/*
  Three-stage synchronisers and edge detection for the count pin and capture pins.
  Assumes the pins are asynchronous to i_ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module mct_edge_sync (
  input  wire logic       i_ref_clk,
  input  wire logic       i_resetn,
  input  wire logic       i_cnt_pin,
  input  wire logic [2:0] i_cap_pin,
  mct_sync_if.src         sync
);
  // Index 3 is the count pin, 0..2 the capture pins
  logic [3:0] s1_r;
  logic [3:0] s2_r;
  logic [3:0] s3_r;
  logic [3:0] lvl_r;

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_sync
      always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
          s1_r[g]  <= 1'b0;
          s2_r[g]  <= 1'b0;
          s3_r[g]  <= 1'b0;
          lvl_r[g] <= 1'b0;
        end else begin
          s1_r[g] <= (g == 3) ? i_cnt_pin : i_cap_pin[g % 3];
          s2_r[g] <= s1_r[g];
          s3_r[g] <= s2_r[g];
          // A change counts only once stages two and three agree
          if (s2_r[g] == s3_r[g]) begin
            lvl_r[g] <= s3_r[g];
          end
        end
      end
    end
  endgenerate

  logic [3:0] agree;
  assign agree         = ~(s2_r ^ s3_r);
  assign sync.cap_rise = agree[2:0] & s3_r[2:0] & ~lvl_r[2:0];
  assign sync.cap_fall = agree[2:0] & ~s3_r[2:0] & lvl_r[2:0];
  assign sync.cnt_rise = agree[3] & s3_r[3] & ~lvl_r[3];
  assign sync.cnt_fall = agree[3] & ~s3_r[3] & lvl_r[3];
endmodule : mct_edge_sync
`default_nettype wire

//--- verilog/mct_prescale.sv
/*
  32-bit prescaler producing a one-cycle tick to the main count.
  Assumes i_adv is a one-cycle pulse on the selected count clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mct_regs.svh"
module mct_prescale (
  input  wire logic                  i_ref_clk,
  input  wire logic                  i_resetn,
  input  wire logic                  i_adv,
  input  wire logic                  i_clr,
  input  wire logic [`MCT_CNT_W-1:0] i_limit,
  output logic      [`MCT_CNT_W-1:0] o_pc,
  output logic                       o_tick
);
  logic [`MCT_CNT_W-1:0] pc_r;

  assign o_tick = i_adv && !i_clr && (pc_r >= i_limit);  // [R12]
  assign o_pc   = pc_r;

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pc_r <= `MCT_CNT_RST;
    end else if (i_clr) begin
      pc_r <= `MCT_CNT_RST;  // [R10]
    end else if (o_tick) begin
      pc_r <= `MCT_CNT_RST;  // [R12]
    end else if (i_adv) begin
      pc_r <= pc_r + 32'h0000_0001;  // [R2]
    end
  end
endmodule : mct_prescale
`default_nettype wire

//--- verilog/mct_timer.sv
/*
  Match/capture 32-bit timer/counter with prescaler, four matches, three captures,
  match outputs, PWM and DMA requests. Control bits are plain ports.
  Assumes a single 40 MHz clock; pins are asynchronous and synchronised here.
*/
// Summary of operation
// R1 - Count system clock or external pin edges
// R2 - 32-bit count fed by 32-bit prescaler
// R3 - Three captures latch count, optional interrupt
// R4 - Four matches; continue counting, optional interrupt
// R5 - Stop-on-match halts the count
// R6 - Reset-on-match returns count to zero
// R7 - Match outputs: low, high, toggle, none
// R8 - Shadowed match values avoid PWM glitches
// R9 - Two matches issue DMA requests
// R10 - Capture event can clear count and prescaler
// R11 - PWM mode on match outputs
// R12 - Count advances at prescale limit, prescaler restarts
// R13 - Reset-on-match register sets PWM period
`timescale 1ns/1ps
`default_nettype none
`include "mct_regs.svh"
module mct_timer (
  input  wire logic                      i_ref_clk,
  input  wire logic                      i_resetn,
  input  wire logic                      i_enable,
  input  wire logic                      i_cnt_reset,
  input  wire logic                      i_cnt_mode,
  input  wire logic [1:0]                i_cnt_edge,
  input  wire logic [`MCT_CNT_W-1:0]     i_prescale,
  input  wire logic [127:0]              i_match_val,
  input  wire logic [3:0]                i_match_irq_en,
  input  wire logic [3:0]                i_match_stop,
  input  wire logic [3:0]                i_match_reset,
  input  wire logic [7:0]                i_match_act,
  input  wire logic [3:0]                i_pwm_en,
  input  wire logic [1:0]                i_dma_en,
  input  wire logic [2:0]                i_cap_rise_en,
  input  wire logic [2:0]                i_cap_fall_en,
  input  wire logic [2:0]                i_cap_irq_en,
  input  wire logic                      i_clr_en,
  input  wire logic [1:0]                i_clr_sel,
  input  wire logic                      i_clr_fall,
  input  wire logic [3:0]                i_match_flag_clr,
  input  wire logic [2:0]                i_cap_flag_clr,
  input  wire logic [1:0]                i_dma_ack,
  input  wire logic                      i_cnt_pin,
  input  wire logic [2:0]                i_cap_pin,
  output logic      [`MCT_CNT_W-1:0]     o_count,
  output logic      [`MCT_CNT_W-1:0]     o_pcount,
  output logic      [95:0]               o_cap_val,
  output logic      [3:0]                o_match_flag,
  output logic      [2:0]                o_cap_flag,
  output logic                           o_irq,
  output logic      [3:0]                o_match_out,
  output logic      [1:0]                o_dma_req,
  output logic                           o_running
);
  mct_sync_if sync ();

  mct_edge_sync u_sync (
    .i_ref_clk (i_ref_clk),
    .i_resetn  (i_resetn),
    .i_cnt_pin (i_cnt_pin),
    .i_cap_pin (i_cap_pin),
    .sync      (sync)
  );

  logic                  adv;
  logic                  tick;
  logic                  cap_clr;
  logic [2:0]            cap_evt;
  logic [3:0]            match_hit;
  logic [`MCT_CNT_W-1:0] cnt_r;
  logic [127:0]          shadow_r;
  mct_pkg::mct_run_t     run_r;

  // Counter mode selects which pin edges advance the prescaler
  always_comb begin
    if (i_cnt_mode) begin
      adv = (i_cnt_edge[0] & sync.cnt_rise) | (i_cnt_edge[1] & sync.cnt_fall);  // [R1]
    end else begin
      adv = 1'b1;  // [R1]
    end
  end

  assign cap_evt = (i_cap_rise_en & sync.cap_rise) | (i_cap_fall_en & sync.cap_fall);
  assign cap_clr = i_clr_en &&
                   (i_clr_fall ? sync.cap_fall[i_clr_sel % 3] : sync.cap_rise[i_clr_sel % 3]);

  mct_prescale u_pre (
    .i_ref_clk (i_ref_clk),
    .i_resetn  (i_resetn),
    .i_adv     (adv && (run_r == mct_pkg::MCT_RUN_CNT)),
    .i_clr     (cap_clr || i_cnt_reset),
    .i_limit   (i_prescale),
    .o_pc      (o_pcount),
    .o_tick    (tick)
  );

  // A match is judged on the tick that would leave the matching value
  genvar m;
  generate
    for (m = 0; m < 4; m++) begin : g_hit
      assign match_hit[m] = tick && (cnt_r == shadow_r[m*32 +: 32]);  // [R4]
    end
  endgenerate

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      run_r <= mct_pkg::MCT_RUN_IDLE;
    end else begin
      case (run_r)
        mct_pkg::MCT_RUN_IDLE: if (i_enable) run_r <= mct_pkg::MCT_RUN_CNT;
        mct_pkg::MCT_RUN_CNT: begin
          if (!i_enable) begin
            run_r <= mct_pkg::MCT_RUN_IDLE;
          end else if (|(match_hit & i_match_stop)) begin
            run_r <= mct_pkg::MCT_RUN_HALT;  // [R5]
          end
        end
        mct_pkg::MCT_RUN_HALT: if (!i_enable) run_r <= mct_pkg::MCT_RUN_IDLE;
        default: run_r <= mct_pkg::MCT_RUN_IDLE;
      endcase
    end
  end
  assign o_running = (run_r == mct_pkg::MCT_RUN_CNT);

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_r <= `MCT_CNT_RST;
    end else if (cap_clr || i_cnt_reset) begin
      cnt_r <= `MCT_CNT_RST;  // [R10]
    end else if (|(match_hit & i_match_reset)) begin
      cnt_r <= `MCT_CNT_RST;  // [R6] [R13]
    end else if (|(match_hit & i_match_stop)) begin
      cnt_r <= cnt_r;  // [R5]
    end else if (tick) begin
      cnt_r <= cnt_r + 32'h0000_0001;  // [R2] [R12]
    end
  end
  assign o_count = cnt_r;

  // Shadows load only when the count wraps, rests at zero or is not counting, so a PWM edge never
  // sees a half-updated period/duty pair
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      shadow_r <= 128'h0;
    end else if (run_r != mct_pkg::MCT_RUN_CNT || cnt_r == `MCT_CNT_RST && !tick
                 || |(match_hit & i_match_reset)) begin
      shadow_r <= i_match_val;  // [R8]
    end
  end

  generate
    for (m = 0; m < 4; m++) begin : g_out
      always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
          o_match_out[m] <= 1'b0;
        end else if (i_pwm_en[m] && !i_match_reset[m]) begin
          // PWM: low at period start, high from the edge match onward
          // A cleared count also starts a period, so a stale high never leaks in
          if (|(match_hit & i_match_reset) || cap_clr || i_cnt_reset) begin
            o_match_out[m] <= 1'b0;  // [R11] [R13]
          end else if (match_hit[m]) begin
            o_match_out[m] <= 1'b1;  // [R11]
          end
        end else if (match_hit[m]) begin
          case (mct_pkg::mct_emact_t'(i_match_act[m*2 +: 2]))
            mct_pkg::MCT_EM_LOW:    o_match_out[m] <= 1'b0;  // [R7]
            mct_pkg::MCT_EM_HIGH:   o_match_out[m] <= 1'b1;  // [R7]
            mct_pkg::MCT_EM_TOGGLE: o_match_out[m] <= ~o_match_out[m];  // [R7]
            default:                o_match_out[m] <= o_match_out[m];
          endcase
        end
      end

      // Set wins over a clear in the same cycle
      always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
          o_match_flag[m] <= 1'b0;
        end else if (match_hit[m]) begin
          o_match_flag[m] <= 1'b1;  // [R4]
        end else if (i_match_flag_clr[m]) begin
          o_match_flag[m] <= 1'b0;
        end
      end
    end
  endgenerate

  genvar c;
  generate
    for (c = 0; c < 3; c++) begin : g_cap
      always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
          o_cap_val[c*32 +: 32] <= `MCT_CNT_RST;
        end else if (cap_evt[c]) begin
          o_cap_val[c*32 +: 32] <= cnt_r;  // [R3]
        end
      end
      always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
          o_cap_flag[c] <= 1'b0;
        end else if (cap_evt[c]) begin
          o_cap_flag[c] <= 1'b1;  // [R3]
        end else if (i_cap_flag_clr[c]) begin
          o_cap_flag[c] <= 1'b0;
        end
      end
    end
  endgenerate

  genvar d;
  generate
    for (d = 0; d < 2; d++) begin : g_dma
      always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
          o_dma_req[d] <= 1'b0;
        end else if (i_dma_en[d] && match_hit[d]) begin
          o_dma_req[d] <= 1'b1;  // [R9]
        end else if (i_dma_ack[d] || !i_dma_en[d]) begin
          o_dma_req[d] <= 1'b0;
        end
      end
    end
  endgenerate

  assign o_irq = |(o_match_flag & i_match_irq_en) | |(o_cap_flag & i_cap_irq_en);  // [R3] [R4]

  reset_clr_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)  // [R10]
    cap_clr |=> (cnt_r == 32'h0 && o_pcount == 32'h0)) else $error("capture clear missed");
  stop_halts_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)  // [R5]
    (|(match_hit & i_match_stop)) && i_enable |=> !o_running) else $error("stop failed");
  match_reset_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)  // [R6]
    (|(match_hit & i_match_reset)) && !cap_clr && !i_cnt_reset |=> cnt_r == 32'h0)
    else $error("reset on match failed");
  count_step_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)  // [R12]
    tick && match_hit == 4'h0 && !cap_clr && !i_cnt_reset |=> cnt_r == $past(cnt_r) + 32'h1)
    else $error("count did not step");
  pre_limit_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)  // [R12]
    tick |=> o_pcount == 32'h0) else $error("prescaler not restarted");
  timer_mode_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)  // [R1]
    !i_cnt_mode && o_running && !cap_clr && !i_cnt_reset && i_prescale == 32'h0 && !tick
    |-> 1'b0) else $error("timer mode tick missing");
  cap_latch_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)  // [R3]
    cap_evt[0] |=> o_cap_val[31:0] == $past(cnt_r) && o_cap_flag[0]) else $error("capture lost");
  dma_req_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)  // [R9]
    i_dma_en[0] && match_hit[0] |=> o_dma_req[0]) else $error("dma request missing");
  out_high_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)  // [R7]
    match_hit[1] && !i_pwm_en[1] && i_match_act[3:2] == 2'b10 |=> o_match_out[1])
    else $error("match output not high");
  // Output actions, PWM edges and shadow loads
  out_low_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)  // [R7]
    match_hit[2] && !i_pwm_en[2] && i_match_act[5:4] == 2'b01 |=> !o_match_out[2])
    else $error("match output not low");
  out_toggle_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)  // [R7]
    match_hit[0] && !i_pwm_en[0] && i_match_act[1:0] == 2'b11
    |=> o_match_out[0] != $past(o_match_out[0])) else $error("match output not toggled");
  out_none_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)  // [R7]
    match_hit[3] && !i_pwm_en[3] && i_match_act[7:6] == 2'b00 |=> $stable(o_match_out[3]))
    else $error("match output moved");
  pwm_rise_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)  // [R11]
    match_hit[1] && i_pwm_en[1] && !i_match_reset[1] && !(|(match_hit & i_match_reset))
    && !cap_clr && !i_cnt_reset |=> o_match_out[1]) else $error("pwm edge missing");
  pwm_wrap_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)  // [R13]
    i_pwm_en[1] && !i_match_reset[1] && (|(match_hit & i_match_reset)) |=> !o_match_out[1])
    else $error("pwm period start missing");
  shadow_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)  // [R8]
    o_running && cnt_r != 32'h0 && !(|(match_hit & i_match_reset)) |=> $stable(shadow_r))
    else $error("shadow changed mid period");
  shadow_load_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)  // [R8]
    (|(match_hit & i_match_reset)) |=> shadow_r == $past(i_match_val))
    else $error("shadow not loaded at wrap");
  // Flags, interrupt, halt, count source and DMA acknowledge
  flag_clear_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)  // [R4]
    i_match_flag_clr[0] && !match_hit[0] |=> !o_match_flag[0])
    else $error("match flag not cleared");
  match_flag_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)  // [R4]
    match_hit[3] |=> o_match_flag[3])
    else $error("match flag not set");
  cap_clear_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)  // [R3]
    i_cap_flag_clr[1] && !cap_evt[1] |=> !o_cap_flag[1])
    else $error("capture flag not cleared");
  irq_level_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)  // [R3]
    (|(o_cap_flag & i_cap_irq_en)) |-> o_irq)
    else $error("capture interrupt missing");
  idle_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)  // [R5]
    !o_running && !cap_clr && !i_cnt_reset |=> $stable(cnt_r))
    else $error("count moved while stopped");
  halt_stays_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)  // [R5]
    run_r == mct_pkg::MCT_RUN_HALT && i_enable |=> run_r == mct_pkg::MCT_RUN_HALT)
    else $error("halt left while enabled");
  pin_mode_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)  // [R1]
    i_cnt_mode && !sync.cnt_rise && !sync.cnt_fall |-> !tick)
    else $error("tick without pin edge");
  pre_step_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)  // [R12]
    o_running && !i_cnt_mode && !tick && !cap_clr && !i_cnt_reset
    |=> o_pcount == $past(o_pcount) + 32'h1) else $error("prescaler did not step");
  dma_ack_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)  // [R9]
    o_dma_req[0] && i_dma_ack[0] && !match_hit[0] |=> !o_dma_req[0])
    else $error("dma request not dropped");
endmodule : mct_timer
`default_nettype wire

//--- verif/mct_pin_model.sv
/*
  Pin-side model: drives the count pin and the capture pins.
  Assumes the bench calls its tasks and shares i_ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module mct_pin_model (
  input  wire logic       i_ref_clk,
  output logic            o_cnt_pin,
  output logic      [2:0] o_cap_pin
);
  initial begin
    o_cnt_pin = 1'b0;
    o_cap_pin = 3'h0;
  end
  // Each level held four clocks so the three-flop synchroniser sees every edge
  task automatic cnt_pulses(input int k);
    repeat (k) begin
      repeat (4) @(posedge i_ref_clk);
      #1 o_cnt_pin = 1'b1;
      repeat (4) @(posedge i_ref_clk);
      #1 o_cnt_pin = 1'b0;
    end
  endtask : cnt_pulses
  task automatic cap_level(input int ch, input logic val);
    @(posedge i_ref_clk);
    #1 o_cap_pin[ch] = val;
  endtask : cap_level
endmodule : mct_pin_model
`default_nettype wire

//--- verif/mct_timer_test.sv
/*
  Self-checking bench for mct_timer, random and corner stimulus.
  Assumes mct_pin_model on the pins; assertions live in the design.
*/
`timescale 1ns/1ps
`default_nettype none
module mct_timer_test;
  logic         i_ref_clk = 1'b0;
  logic         i_resetn  = 1'b0;
  logic         i_enable, i_cnt_reset, i_cnt_mode, i_clr_en, i_clr_fall, i_cnt_pin, o_irq, o_running;
  logic [1:0]   i_cnt_edge, i_dma_en, i_clr_sel, i_dma_ack, o_dma_req;
  logic [2:0]   i_cap_rise_en, i_cap_fall_en, i_cap_irq_en, i_cap_flag_clr, i_cap_pin, o_cap_flag;
  logic [3:0]   i_match_irq_en, i_match_stop, i_match_reset, i_pwm_en, i_match_flag_clr;
  logic [3:0]   o_match_flag, o_match_out;
  logic [7:0]   i_match_act;
  logic [31:0]  i_prescale, o_count, o_pcount, v;
  logic [95:0]  o_cap_val;
  logic [127:0] i_match_val;
  int           fail_count = 0, check_count = 0, n, p, m, c, w;

  always #12.5 i_ref_clk = ~i_ref_clk;

  mct_timer dut (.i_ref_clk, .i_resetn, .i_enable, .i_cnt_reset, .i_cnt_mode, .i_cnt_edge,
    .i_prescale, .i_match_val, .i_match_irq_en, .i_match_stop, .i_match_reset, .i_match_act,
    .i_pwm_en, .i_dma_en, .i_cap_rise_en, .i_cap_fall_en, .i_cap_irq_en, .i_clr_en, .i_clr_sel,
    .i_clr_fall, .i_match_flag_clr, .i_cap_flag_clr, .i_dma_ack, .i_cnt_pin, .i_cap_pin,
    .o_count, .o_pcount, .o_cap_val, .o_match_flag, .o_cap_flag, .o_irq, .o_match_out,
    .o_dma_req, .o_running);
  mct_pin_model pins (.i_ref_clk, .o_cnt_pin(i_cnt_pin), .o_cap_pin(i_cap_pin));

  task automatic tick(input int k);
    repeat (k) @(posedge i_ref_clk);
    #1;
  endtask : tick
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask : chk
  // Bounded wait for a count value; k returns the cycles spent
  task automatic wait_cnt(input logic [31:0] val, output int k);
    k = 0;
    while (o_count !== val && k < 3000) begin
      tick(1);
      k++;
    end
    if (k == 3000) chk("count reached", o_count, val);
  endtask : wait_cnt
  // Enable goes low for a cycle so a halted count may restart
  task automatic restart();
    i_enable = 1'b0;
    i_cnt_reset = 1'b1;
    i_match_flag_clr = 4'hf;
    i_cap_flag_clr = 3'h7;
    tick(1);
    {i_cnt_reset, i_match_flag_clr, i_cap_flag_clr} = '0;
    i_enable = 1'b1;
  endtask : restart
  // Period is 21 counts (reset match at 20)
  task automatic pwm_high(output int h);
    wait_cnt(32'h1, n);
    h = 0;
    repeat (21) begin
      h += (o_match_out[1] === 1'b1);
      tick(1);
    end
  endtask : pwm_high
  task automatic end_sim();
    if (fail_count == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim

  initial begin
    #(25 * 60000);
    fail_count++;
    end_sim();
  end

  initial begin
    {i_enable, i_cnt_reset, i_cnt_mode, i_clr_en, i_clr_fall, i_cnt_edge, i_dma_en, i_clr_sel,
     i_dma_ack, i_cap_rise_en, i_cap_fall_en, i_cap_irq_en, i_cap_flag_clr, i_match_irq_en,
     i_match_stop, i_match_reset, i_pwm_en, i_match_flag_clr, i_match_act, i_prescale} = '0;
    i_match_val = {4{32'hffff_ff00}};
    void'($urandom(32'h07af55c1));
    tick(10);
    i_resetn = 1'b1;
    chk("outputs after reset", {o_match_flag, o_cap_flag, o_match_out, o_dma_req, o_irq}, 0);
    for (int k = 0; k < 4; k++) begin
      p = (k < 2) ? k * 3 : $urandom % 6;
      i_prescale = p;
      restart();
      wait_cnt(32'h1, n);
      wait_cnt(32'h2, n);
      chk("tick spacing", n, p + 1);
      chk("prescaler restart", o_pcount, 32'h0);
    end
    m = 6 + $urandom % 10;
    i_prescale = 32'h0;
    i_match_val = {4{32'(m)}};
    i_match_reset = 4'h1;
    i_match_act = 8'b00_01_10_11;
    i_match_irq_en = 4'hf;
    i_dma_en = 2'b11;
    restart();
    wait_cnt(32'(m), n);
    wait_cnt(32'h0, n);
    chk("wrap delay", n, 1);
    chk("match outputs", o_match_out, 4'b0011);
    chk("match flags", {o_irq, o_match_flag}, 5'h1f);
    chk("dma requests", o_dma_req, 2'b11);
    i_dma_ack = 2'b01;
    tick(1);
    i_dma_ack = 2'b00;
    tick(1);
    chk("dma after ack", o_dma_req, 2'b10);
    wait_cnt(32'h0, n);
    chk("outputs second wrap", o_match_out, 4'b0010);
    i_match_reset = 4'h0;
    i_match_stop = 4'h4;
    i_match_val = {32'hffff_ff00, 32'(m + 4), 32'hffff_ff00, 32'(m + 1)};
    restart();
    wait_cnt(32'(m + 4), n);
    chk("passed match flag", o_match_flag[0], 1'b1);
    tick(5);
    chk("held count", o_count, m + 4);
    chk("halted", o_running, 1'b0);
    i_match_stop = 4'h0;
    i_match_irq_en = 4'h0;
    i_match_val = {4{32'hffff_ff00}};
    i_cap_rise_en = 3'h7;
    i_cap_irq_en = 3'h7;
    c = $urandom % 3;
    restart();
    tick(20);
    pins.cap_level(c, 1'b1);
    v = o_count;
    tick(8);
    v = o_cap_val[c * 32 +: 32] - v;
    chk("capture lag", v >= 2 && v <= 6, 1);
    chk("capture flag", {o_irq, o_cap_flag}, {1'b1, 3'(1 << c)});
    i_cap_fall_en = 3'h7;
    pins.cap_level(c, 1'b0);
    tick(8);
    i_clr_en = 1'b1;
    i_clr_sel = 2'(c);
    tick(30);
    w = 10 + $urandom % 20;
    pins.cap_level(c, 1'b1);
    tick(w);
    pins.cap_level(c, 1'b0);
    tick(8);
    v = o_cap_val[c * 32 +: 32];
    chk("pulse width", v + 2 >= w && v <= w + 2, 1);
    i_clr_fall = 1'b1;
    pins.cap_level(c, 1'b1);
    tick(8);
    pins.cap_level(c, 1'b0);
    tick(w);
    pins.cap_level(c, 1'b1);
    tick(8);
    v = o_cap_val[c * 32 +: 32];
    chk("low pulse width", v + 2 >= w && v <= w + 2, 1);
    i_clr_en = 1'b0;
    i_cnt_mode = 1'b1;
    for (int e = 1; e < 4; e++) begin
      i_cnt_edge = 2'(e);
      restart();
      n = 2 + $urandom % 5;
      pins.cnt_pulses(n);
      tick(6);
      chk("pin edge count", o_count, (e == 3) ? 2 * n : n);
    end
    i_cnt_mode = 1'b0;
    i_pwm_en = 4'b0010;
    i_match_reset = 4'h1;
    i_match_act = 8'h0;
    i_match_val = {32'hffff_ff00, 32'hffff_ff00, 32'h5, 32'h14};
    restart();
    pwm_high(w);
    chk("pwm high time", w >= 14 && w <= 16, 1);
    p = 5 + $urandom % 10;
    tick(5);
    i_match_val[63:32] = 32'(p);
    pwm_high(w);
    pwm_high(w);
    chk("pwm after update", w >= 19 - p && w <= 21 - p, 1);
    end_sim();
  end
endmodule : mct_timer_test
`default_nettype wire
